/* verilog/input_capture_channel.sv */
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module input_capture_channel (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        capture_input_pin,
   input  wire logic [15:0] second_timer_count,
   input  wire logic [15:0] third_timer_count,
   input  wire logic        cpu_idle,
   input  wire logic        cpu_sleep,
   output logic             irq,
   output logic             wake_req
);
   // ****************************************************************
   // State.
   // ****************************************************************
   typedef struct packed {
      logic [2:0]  pin_sync;
      logic [15:0] ctrl;
      logic [3:0]  presc;
      logic [1:0]  int_cnt;
      logic        ovf;
      logic [capture_pkg::num_events-1:0] status;
      logic [capture_pkg::num_events-1:0] mask;
      logic [31:0] rdata;
      logic        ready;
      logic        err;
      logic        irq;
      logic        wake;
   } chan_state_t;

   chan_state_t          s_q;
   chan_state_t          s_d;
   capture_pkg::fifo_req_t fifo_req;
   logic [15:0]          fifo_head;
   logic                 fifo_ne;
   logic                 fifo_full;

   logic [2:0]  mode;
   logic        halted;
   logic        rise;
   logic        fall;
   logic        event_hit;
   logic        presc_wrap;
   logic [3:0]  presc_last;
   logic        setup;
   logic        wr_ctrl;
   logic        rd_value;
   logic        int_hit;
   logic [15:0] ctrl_view;
   logic [capture_pkg::num_events-1:0] ev;

   capture_fifo u_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .req       (fifo_req),
      .head      (fifo_head),
      .not_empty (fifo_ne),
      .full      (fifo_full)
   );

   // ****************************************************************
   // Edge detection and event qualification.
   // ****************************************************************
   // Only the second and third sync stages feed the edge detector, so a
   // metastable first stage never reaches any logic.
   always_comb begin
      mode   = s_q.ctrl[2:0];
      halted = s_q.ctrl[capture_pkg::sidl_bit] && cpu_idle;
      rise   = s_q.pin_sync[1] && !s_q.pin_sync[2];
      fall   = !s_q.pin_sync[1] && s_q.pin_sync[2];
      presc_last = (mode == capture_pkg::mode_div16) ?
                   capture_pkg::div16_last : capture_pkg::div4_last;
      presc_wrap = rise && (s_q.presc == presc_last);
      case (mode)
         capture_pkg::mode_both:  event_hit = rise || fall;
         capture_pkg::mode_fall:  event_hit = fall;
         capture_pkg::mode_rise:  event_hit = rise;
         capture_pkg::mode_div4,
         capture_pkg::mode_div16: event_hit = presc_wrap;
         default:                 event_hit = 1'b0;
      endcase
      if (halted) begin
         event_hit = 1'b0;
      end
   end

   // ****************************************************************
   // APB decode. Zero wait states; unmapped addresses answer an error.
   // ****************************************************************
   always_comb begin
      setup    = psel && !penable;
      wr_ctrl  = setup && pwrite && (paddr == capture_pkg::ctrl_addr);
      rd_value = setup && !pwrite && (paddr == capture_pkg::value_addr);
      ctrl_view = s_q.ctrl & capture_pkg::ctrl_wmask;
      ctrl_view[capture_pkg::ov_bit]  = s_q.ovf;
      ctrl_view[capture_pkg::bne_bit] = fifo_ne;
   end

   // ****************************************************************
   // Next state.
   // ****************************************************************
   always_comb begin
      s_d = s_q;
      s_d.pin_sync = {s_q.pin_sync[1:0], capture_input_pin};

      // Capture the selected timer into the FIFO.
      fifo_req.data = s_q.ctrl[capture_pkg::tsel_bit] ?
                      second_timer_count : third_timer_count;
      fifo_req.push = event_hit;
      fifo_req.pop  = rd_value;

      // Prescaler counts rising edges in the divided modes only.
      if (halted) begin
         s_d.presc = s_q.presc;
      end else if (mode == capture_pkg::mode_div4 ||
                   mode == capture_pkg::mode_div16) begin
         if (presc_wrap) begin
            s_d.presc = '0;
         end else if (rise) begin
            s_d.presc = s_q.presc + 4'h1;
         end
      end else begin
         s_d.presc = '0;
      end

      // Interrupt rate; both-edge mode interrupts on every capture.
      int_hit = 1'b0;
      if (event_hit) begin
         if (mode == capture_pkg::mode_both ||
             s_q.int_cnt == s_q.ctrl[capture_pkg::ici_lo +: 2]) begin
            int_hit   = 1'b1;
            s_d.int_cnt = '0;
         end else begin
            s_d.int_cnt = s_q.int_cnt + 2'h1;
         end
      end

      // Overflow is hardware set; it clears once the buffer drains.
      if (event_hit && fifo_full) begin
         s_d.ovf = 1'b1;
      end else if (!fifo_ne) begin
         s_d.ovf = 1'b0;
      end

      // Wake: rising edge in sleep or idle when in wake mode, any capture in sleep or idle.
      s_d.wake = (mode == capture_pkg::mode_wake && rise &&
                  (cpu_sleep || cpu_idle)) ||
                 (event_hit && (cpu_sleep || cpu_idle));

      ev = '0;
      ev[capture_pkg::ev_cap]  = int_hit;
      ev[capture_pkg::ev_ovf]  = event_hit && fifo_full;
      ev[capture_pkg::ev_wake] = s_d.wake;

      // Register writes; a new mode restarts the counters.
      if (wr_ctrl) begin
         s_d.ctrl = pwdata[15:0] & capture_pkg::ctrl_wmask;
         s_d.int_cnt = '0;
         s_d.presc = '0;
      end
      if (setup && pwrite && paddr == capture_pkg::mask_addr) begin
         s_d.mask = pwdata[capture_pkg::num_events-1:0];
      end
      // Write one to clear, but a new event in the same cycle wins.
      s_d.status = s_q.status;
      if (setup && pwrite && paddr == capture_pkg::status_addr) begin
         s_d.status = s_q.status & ~pwdata[capture_pkg::num_events-1:0];
      end
      s_d.status = s_d.status | ev;

      // Read data is prepared in setup and shown in the access phase.
      s_d.ready = setup;
      s_d.err   = 1'b0;
      s_d.rdata = '0;
      if (setup) begin
         case (paddr)
            capture_pkg::ctrl_addr:   s_d.rdata = {16'h0000, ctrl_view};
            capture_pkg::value_addr:  s_d.rdata = pwrite ? 32'h0 :
                                                  {16'h0000, fifo_head};
            capture_pkg::status_addr: s_d.rdata = {29'h0, s_q.status};
            capture_pkg::mask_addr:   s_d.rdata = {29'h0, s_q.mask};
            default:                  s_d.err   = 1'b1;
         endcase
      end
      s_d.irq = |(s_d.status & s_d.mask);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Outputs, all from flip-flops.
   // ****************************************************************
   assign prdata   = s_q.rdata;
   assign pready   = s_q.ready;
   assign pslverr  = s_q.err;
   assign irq      = s_q.irq;
   assign wake_req = s_q.wake;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   sel_timer_a: assert property (@(posedge clk) disable iff (sys_rst)
      event_hit && !fifo_full && !s_q.ctrl[capture_pkg::tsel_bit]
      |-> fifo_req.data == third_timer_count)
      else $error("wrong timer captured");
   off_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == capture_pkg::mode_off || mode == 3'h6) |-> !event_hit)
      else $error("capture in disabled mode");
   rise_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
      mode == capture_pkg::mode_rise && !halted && rise |-> event_hit)
      else $error("rising edge not captured");
   fall_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
      mode == capture_pkg::mode_fall && !halted && fall |-> event_hit)
      else $error("falling edge not captured");
   idle_halt_a: assert property (@(posedge clk) disable iff (sys_rst)
      s_q.ctrl[capture_pkg::sidl_bit] && cpu_idle |-> !event_hit)
      else $error("capture while halted");
   ovf_set_a: assert property (@(posedge clk) disable iff (sys_rst)
      event_hit && fifo_full |=> s_q.ovf)
      else $error("overflow not flagged");
   bne_read_a: assert property (@(posedge clk) disable iff (sys_rst)
      s_q.ready && !s_q.err && s_q.rdata[31:16] == 16'h0 &&
      $past(paddr) == capture_pkg::ctrl_addr && $past(setup) && !$past(pwrite)
      |-> s_q.rdata[capture_pkg::bne_bit] == $past(fifo_ne))
      else $error("not-empty bit wrong");
   rsvd_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      (s_q.ctrl & ~capture_pkg::ctrl_wmask) == 16'h0)
      else $error("reserved bit set");
   wake_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
      mode == capture_pkg::mode_wake && rise && cpu_sleep |=> wake_req)
      else $error("wake not raised");
   every_int_a: assert property (@(posedge clk) disable iff (sys_rst)
      event_hit && s_q.ctrl[capture_pkg::ici_lo +: 2] == 2'b00 |=>
      s_q.status[capture_pkg::ev_cap])
      else $error("interrupt missed");
endmodule : input_capture_channel
`default_nettype wire

/* verilog/capture_pkg.sv */
// Behaviour
// - Each pin event latches the selected 16-bit timer count.
// - Timer select set picks the second timer, clear the third.
// - The per-interrupt field interrupts every 1st to 4th capture.
// - A read-only overflow flag is set and cleared by hardware.
// - A read-only not-empty bit shows a capture remains unread.
// - Captures are kept in a four-entry FIFO of 16-bit values.
// - Mode 111 is a rising-edge wake source only in sleep or idle.
// - Modes 000 and 110 disable the channel and perform no captures.
// - Mode 101 captures every 16th rising edge, mode 100 every 4th.
// - Mode 011 captures rising edges and mode 010 falling edges.
// - Mode 001 captures on both edges and interrupts on every capture.
// - With stop-in-idle set the channel stops capturing in idle; mode 111 still wakes on rising edges.
// - A pin event can wake the device from sleep and idle.
// - Unimplemented control bits read as zero.
package capture_pkg;

   // ****************************************************************
   // Register map, byte addresses on the APB.
   // ****************************************************************
   localparam logic [7:0] ctrl_addr   = 8'h00;
   localparam logic [7:0] value_addr  = 8'h04;
   localparam logic [7:0] status_addr = 8'h08;
   localparam logic [7:0] mask_addr   = 8'h0c;

   // ****************************************************************
   // Control field layout.
   // ****************************************************************
   localparam int sidl_bit  = 13;
   localparam int tsel_bit  = 7;
   localparam int ici_lo    = 5;
   localparam int ov_bit    = 4;
   localparam int bne_bit   = 3;
   localparam logic [15:0] ctrl_wmask = 16'h20e7;

   localparam logic [2:0] mode_off   = 3'h0;
   localparam logic [2:0] mode_both  = 3'h1;
   localparam logic [2:0] mode_fall  = 3'h2;
   localparam logic [2:0] mode_rise  = 3'h3;
   localparam logic [2:0] mode_div4  = 3'h4;
   localparam logic [2:0] mode_div16 = 3'h5;
   localparam logic [2:0] mode_wake  = 3'h7;

   localparam logic [3:0] div4_last  = 4'h3;
   localparam logic [3:0] div16_last = 4'hf;

   // Status bits: 0 capture interrupt, 1 overflow, 2 wake event.
   localparam int num_events = 3;
   localparam int ev_cap  = 0;
   localparam int ev_ovf  = 1;
   localparam int ev_wake = 2;

   localparam int fifo_depth = 4;
   localparam int ptr_w      = 2;

   typedef struct packed {
      logic [15:0] data;
      logic        push;
      logic        pop;
   } fifo_req_t;

endpackage : capture_pkg

/* verilog/capture_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module capture_fifo (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire capture_pkg::fifo_req_t req,
   output logic [15:0]                head,
   output logic                       not_empty,
   output logic                       full
);
   typedef struct packed {
      logic [capture_pkg::fifo_depth-1:0][15:0] mem;
      logic [capture_pkg::ptr_w-1:0]            rd;
      logic [capture_pkg::ptr_w-1:0]            wr;
      logic [capture_pkg::ptr_w:0]              cnt;
   } fifo_state_t;

   fifo_state_t s_q;
   fifo_state_t s_d;
   logic        do_push;
   logic        do_pop;

   // Push is refused when full; the caller flags that as overflow.
   always_comb begin
      do_push = req.push && !full;
      do_pop  = req.pop && not_empty;
      s_d = s_q;
      if (do_push) begin
         s_d.mem[s_q.wr] = req.data;
         s_d.wr = s_q.wr + 1'b1;
      end
      if (do_pop) begin
         s_d.rd = s_q.rd + 1'b1;
      end
      s_d.cnt = s_q.cnt + {2'b00, do_push} - {2'b00, do_pop};
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign head      = s_q.mem[s_q.rd];
   assign not_empty = (s_q.cnt != '0);
   assign full      = (s_q.cnt == 3'(capture_pkg::fifo_depth));

   // Occupancy never exceeds the depth.
   fifo_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
      s_q.cnt <= 3'(capture_pkg::fifo_depth))
      else $error("fifo count above depth");
endmodule : capture_fifo
`default_nettype wire

/* sim/capture_pin_source.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// External signal source for the capture pin.
// ****************************************************************
module capture_pin_source (
   input  wire logic clk,
   output logic      pin
);
   // Each level is held long enough for the synchroniser to see it.
   localparam int hold_cycles = 6;

   // The pin rests low between pulses, as a driven source would.
   initial pin = 1'b0;

   // One pulse is a rising edge followed by a falling edge.
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk);
         pin <= 1'b1;
         repeat (hold_cycles) @(posedge clk);
         pin <= 1'b0;
         repeat (hold_cycles) @(posedge clk);
      end
   endtask : pulses
endmodule : capture_pin_source
`default_nettype wire

/* sim/input_capture_channel_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module input_capture_channel_tb;
   logic        clk, sys_rst, psel, penable, pwrite, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, pin, cpu_idle, cpu_sleep, irq, wake_req;
   logic [15:0] sec_count, thr_count;
   logic        wake_seen;
   int          bad_count, checks_done;

   input_capture_channel uut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .capture_input_pin(pin), .second_timer_count(sec_count),
      .third_timer_count(thr_count), .cpu_idle(cpu_idle),
      .cpu_sleep(cpu_sleep), .irq(irq), .wake_req(wake_req));
   capture_pin_source src (.clk(clk), .pin(pin));

   // ****************************************************************
   // Clock, wake pulse catcher and watchdog.
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // The wake output is a single-cycle pulse, so it is latched here.
   always @(posedge clk) if (wake_req === 1'b1) wake_seen <= 1'b1;

   // The whole run needs under a thousand cycles; this is far beyond.
   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      finish_test;
   end

   // ****************************************************************
   // Bus, comparison and closing tasks.
   // ****************************************************************
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) bad_count++;
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic check_word(input string what, input logic [31:0] exp,
                             input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic check_flag(input string what, input logic exp,
                             input logic got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask : check_flag

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task automatic t_regs;
      check_flag("irq after reset", 1'b0, irq);
      apb(1'b1, capture_pkg::ctrl_addr, 32'hffff_ffff);
      apb(1'b0, capture_pkg::ctrl_addr, 32'h0);
      check_word("control", 32'h0000_20e7, rd);
      apb(1'b0, 8'h10, 32'h0);
      check_flag("unmapped", 1'b1, err);
   endtask : t_regs

   // Each mode gets one pulse; odd rows pick the second timer.
   task automatic t_modes;
      logic [2:0] md[6] = '{3'h3, 3'h2, 3'h1, 3'h0, 3'h6, 3'h7};
      int         cnt[6] = '{1, 1, 2, 0, 0, 0};
      for (int i = 0; i < 6; i++) begin
         thr_count <= 16'(16'h5678 + i);
         apb(1'b1, capture_pkg::ctrl_addr, {24'h0, i[0], 4'h0, md[i]});
         src.pulses(1);
         apb(1'b0, capture_pkg::ctrl_addr, 32'h0);
         check_flag("not empty", cnt[i] > 0, rd[3]);
         repeat (cnt[i]) begin
            apb(1'b0, capture_pkg::value_addr, 32'h0);
            check_word("value", {16'h0, i[0] ? sec_count : thr_count},
                       rd);
         end
      end
   endtask : t_modes

   task automatic t_prescale;
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, capture_pkg::ctrl_addr, {29'h0, 2'b10, i[0]});
         src.pulses(i[0] ? 15 : 3);
         apb(1'b0, capture_pkg::ctrl_addr, 32'h0);
         check_flag("early capture", 1'b0, rd[3]);
         src.pulses(1);
         apb(1'b0, capture_pkg::ctrl_addr, 32'h0);
         check_flag("prescaled capture", 1'b1, rd[3]);
         apb(1'b0, capture_pkg::value_addr, 32'h0);
      end
   endtask : t_prescale

   // Five captures into four places: the last one must be dropped.
   task automatic t_fifo;
      apb(1'b1, capture_pkg::ctrl_addr, 32'h0000_0083);
      for (int i = 0; i < 5; i++) begin
         sec_count <= 16'(16'h0a00 + i);
         src.pulses(1);
      end
      apb(1'b0, capture_pkg::ctrl_addr, 32'h0);
      check_word("full control", 32'h0000_009b, rd);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, capture_pkg::value_addr, 32'h0);
         check_word("fifo order", 32'(16'h0a00 + i), rd);
      end
      apb(1'b0, capture_pkg::ctrl_addr, 32'h0);
      check_word("empty control", 32'h0000_0083, rd);
      apb(1'b1, capture_pkg::status_addr, 32'h7);
   endtask : t_fifo

   task automatic t_irq;
      apb(1'b1, capture_pkg::mask_addr, 32'h1);
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, capture_pkg::ctrl_addr, {25'h0, k[1:0], 5'h03});
         src.pulses(k);
         check_flag("irq early", 1'b0, irq);
         src.pulses(1);
         check_flag("irq due", 1'b1, irq);
         apb(1'b1, capture_pkg::status_addr, 32'h1);
         check_flag("irq cleared", 1'b0, irq);
         repeat (k + 1) apb(1'b0, capture_pkg::value_addr, 32'h0);
      end
      apb(1'b1, capture_pkg::mask_addr, 32'h0);
      apb(1'b1, capture_pkg::ctrl_addr, 32'h0000_0061);
      src.pulses(1);
      check_flag("irq masked", 1'b0, irq);
      apb(1'b1, capture_pkg::mask_addr, 32'h1);
      check_flag("irq both edges", 1'b1, irq);
      apb(1'b1, capture_pkg::status_addr, 32'h7);
      repeat (2) apb(1'b0, capture_pkg::value_addr, 32'h0);
   endtask : t_irq

   task automatic t_idle;
      check_flag("wake while awake", 1'b0, wake_seen);
      cpu_idle <= 1'b1;
      apb(1'b1, capture_pkg::ctrl_addr, 32'h0000_2003);
      src.pulses(1);
      apb(1'b0, capture_pkg::ctrl_addr, 32'h0);
      check_flag("halted in idle", 1'b0, rd[3]);
      apb(1'b1, capture_pkg::ctrl_addr, 32'h0000_0003);
      src.pulses(1);
      apb(1'b0, capture_pkg::value_addr, 32'h0);
      check_word("idle capture", {16'h0, thr_count}, rd);
      // Clear the wake bit left by the idle capture so the sleep check
      // below can only pass on a fresh wake event.
      apb(1'b1, capture_pkg::status_addr, 32'h7);
      cpu_idle  <= 1'b0;
      cpu_sleep <= 1'b1;
      wake_seen <= 1'b0;
      apb(1'b1, capture_pkg::ctrl_addr, 32'h0000_0007);
      src.pulses(1);
      check_flag("wake pulse", 1'b1, wake_seen);
      apb(1'b0, capture_pkg::status_addr, 32'h0);
      check_flag("wake status", 1'b1, rd[capture_pkg::ev_wake]);
      cpu_sleep <= 1'b0;
   endtask : t_idle

   // Reset is held ten cycles, then the scenarios run in turn.
   initial begin
      {sys_rst, psel, penable, pwrite, cpu_idle, cpu_sleep} = 6'h20;
      paddr     = 8'h00;
      pwdata    = 32'h0;
      sec_count = 16'h1234;
      thr_count = 16'h5678;
      wake_seen = 1'b0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs;
      t_modes;
      t_prescale;
      t_fifo;
      t_irq;
      t_idle;
      finish_test;
   end
endmodule : input_capture_channel_tb
`default_nettype wire
